// ==== verification/serial_host_model.sv ====
// Behavioural two-wire bus host issuing 16-bit register word writes and reads.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module serial_host_model #(
    // Arbitrary bus address; the value carries no meaning.
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // -------------------------------------------------------------------
    // Bus phases
    // -------------------------------------------------------------------
    // Each phase lasts 8 core cycles, longer than the device's synchroniser and output register delay.
    task automatic wt();
        repeat (8) @(negedge clock_i);
    endtask : wt

    // Serves both the first start and a repeated start.
    task automatic start();
        sda_oe_o = 1'b0;
        wt();
        scl_o = 1'b1;
        wt();
        sda_oe_o = 1'b1;
        wt();
        scl_o = 1'b0;
        wt();
    endtask : start

    task automatic stop();
        sda_oe_o = 1'b1;
        wt();
        scl_o = 1'b1;
        wt();
        sda_oe_o = 1'b0;
        wt();
    endtask : stop

    // Data only changes a full phase after the clock falls.
    task automatic bit_io(input logic b, output logic s);
        sda_oe_o = !b;
        wt();
        scl_o = 1'b1;
        wt();
        s = sda_i;
        scl_o = 1'b0;
        wt();
    endtask : bit_io

    task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] r,
                        output logic nak);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            r[i] = b;
        end
        bit_io(ack, nak);
    endtask : xfer

    // -------------------------------------------------------------------
    // Register word transfers
    // -------------------------------------------------------------------
    task automatic write_word(input logic [6:0] dev, input logic [7:0] ofs,
                              input logic [15:0] w, output logic nak);
        logic [7:0] r;
        logic n;
        start();
        xfer({dev, 1'b0}, 1'b1, r, nak);
        xfer(ofs, 1'b1, r, n);
        xfer(w[15:8], 1'b1, r, n);
        xfer(w[7:0], 1'b1, r, n);
        stop();
    endtask : write_word

    task automatic read_word(input logic [7:0] ofs, output logic [15:0] w);
        logic [7:0] r;
        logic n;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, r, n);
        xfer(ofs, 1'b1, r, n);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, r, n);
        xfer(8'hff, 1'b0, r, n);
        w[15:8] = r;
        xfer(8'hff, 1'b1, r, n);
        w[7:0] = r;
        stop();
    endtask : read_word
endmodule : serial_host_model

`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the backlight configuration register bank.
// Assumes the serial host model as the only bus master on the resolved data wire.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import backlight_cfg_pkg::*;
    // Arbitrary bus address; the value carries no meaning.
    localparam logic [6:0] DEV = 7'h2a;
    localparam int RAMP_TAB [8] = '{0, 1, 2, 50, 100, 200, 300, 500};
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic allow = 1'b1;
    logic scl, host_oe, sda_o, sda_oe, rnd, smo, byp;
    logic [15:0] brt;
    logic [1:0] bsrc, rate, wid;
    logic [11:0] cur;
    logic [9:0] ramp;
    logic [2:0] dith;
    wire logic sda = !(host_oe || sda_oe);
    int m [3];
    int src, fails, checks_done;

    always #2.5 clock_i = ~clock_i;

    backlight_dimming_config_regs #(.DEVICE_ADDR(DEV)) i_backlight_dimming_config_regs (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .config_write_allow_i(allow),
        .brightness_level_o(brt), .brightness_source_o(bsrc), .sink_current_code_o(cur),
        .spread_modulation_rate_o(rate), .spread_width_o(wid), .random_spread_enable_o(rnd),
        .ramp_time_ms_o(ramp), .smooth_ramp_o(smo), .ramp_bypass_o(byp),
        .extra_resolution_bits_o(dith));

    serial_host_model #(.DEV_ADDR(DEV)) i_serial_host_model (
        .clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

    // -------------------------------------------------------------------
    // Checking tasks
    // -------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk_outs();
        int c, t, d;
        c = m[2];
        d = (c >> 2) & 7;
        t = RAMP_TAB[(c >> 5) & 7];
        if (c & 2) begin
            t = t + t / 2;
        end
        check(brt, 16'(m[0]));
        check(16'(sda_o), 16'h0000);
        check(16'(bsrc), 16'(src));
        check(16'(cur), 16'(m[1] & 'hfff));
        check(16'(rate), 16'((c >> 12) & 3));
        check(16'(wid), 16'((c >> 10) & 3));
        check(16'(rnd), 16'((c >> 14) & 1));
        check(16'(ramp), 16'(t));
        check(16'(smo), 16'((c >> 1) & 1));
        check(16'(byp), 16'(((c >> 5) & 7) == 0));
        check(16'(dith), 16'(d > 4 ? 4 : d));
    endtask : chk_outs

    task automatic rd(input int ofs);
        logic [15:0] v;
        i_serial_host_model.read_word(8'(ofs), v);
        check(v, 16'(ofs < 6 ? m[ofs / 2] : 0));
    endtask : rd

    // Writes a word, updates the reference and checks outputs and read-back.
    task automatic wr(input logic [6:0] dev, input int ofs, input int w);
        logic nak;
        i_serial_host_model.write_word(dev, 8'(ofs), 16'(w), nak);
        check(16'(nak), 16'(dev != DEV));
        if (allow && dev == DEV && ofs < 6) begin
            m[ofs / 2] = w & 'hffff;
            if (ofs == 4 && ((w >> 8) & 1) == 0) begin
                src = (w >> 8) & 3;
            end
        end
        repeat (8) @(negedge clock_i);
        chk_outs();
        rd(ofs);
    endtask : wr

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        int w;
        void'($urandom(32'h35ab45b9));
        m = '{0, 'hfff, 'h8a3};
        src = 0;
        repeat (12) @(negedge clock_i);
        reset_n_i = 1'b1;
        repeat (6) @(negedge clock_i);
        chk_outs();
        for (int o = 0; o < 8; o += 2) begin
            rd(o);
        end
        // Every field code; 1 and 2 ms ramps stay linear.
        for (int i = 0; i < 8; i++) begin
            w = {i[1], i[0], i[1:0], i[1:0], i[1:0], i[2:0], i[2:0], i > 2 && i[0], 1'b1};
            wr(DEV, 4, w);
        end
        wr(DEV, 2, 'h5a5a);
        wr(DEV, 0, 'hc3e1);
        for (int k = 0; k < 12; k++) begin
            allow = ($urandom % 4) != 0;
            w = $urandom;
            if (((w >> 5) & 7) inside {1, 2}) begin
                w = w & ~2;
            end
            wr(DEV, 2 * ($urandom % 4), w);
        end
        allow = 1'b1;
        wr(DEV ^ 7'h01, 2, 'h0abc);
        close_out();
    end

    initial begin
        repeat (90000) @(posedge clock_i);
        fails++;
        close_out();
    end
endmodule : tb_top

`default_nettype wire

// ==== verilog/backlight_cfg_pkg.sv ====
// Constants and field layouts for the backlight dimming configuration register bank.
// Assumes a single 200 MHz core clock and a two-wire serial host bus.
package backlight_cfg_pkg;

    // -------------------------------------------------------------------
    // Register offsets and reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_BRIGHTNESS_LEVEL = 8'h00;
    localparam logic [7:0] OFS_SINK_CURRENT = 8'h02;
    localparam logic [7:0] OFS_DIM_SPREAD_CFG = 8'h04;
    localparam logic [7:0] OFS_STEP = 8'h02;
    localparam logic [15:0] RST_BRIGHTNESS_LEVEL = 16'h0000;
    localparam logic [15:0] RST_SINK_CURRENT = 16'h0fff;
    localparam logic [15:0] RST_DIM_SPREAD_CFG = 16'h08a3;
    localparam int SINK_CODE_W = 12;

    // -------------------------------------------------------------------
    // Field codes
    // -------------------------------------------------------------------
    localparam logic [1:0] SRC_PWM_INPUT = 2'h0;
    localparam logic [1:0] SRC_REGISTER = 2'h2;
    localparam logic [2:0] RAMP_OFF = 3'h0;
    localparam logic [2:0] DITHER_MAX = 3'h4;
    localparam int RAMP_MS_W = 10;

    // Linear ramp times in ms, indexed by ramp_duration_select.
    localparam logic [RAMP_MS_W-1:0] RAMP_MS [8] = '{
        10'h000, 10'h001, 10'h002, 10'h032, 10'h064, 10'h0c8, 10'h12c, 10'h1f4};

    // Layout of the dimming_and_spread_config word, bit 15 first.
    typedef struct packed {
        logic reserved_hi;
        logic random_spread_enable;
        logic [1:0] spread_modulation_rate;
        logic [1:0] spread_width;
        logic [1:0] brightness_source_select;
        logic [2:0] ramp_duration_select;
        logic [2:0] extra_resolution_bits;
        logic smooth_ramp_enable;
        logic reserved_lo;
    } dim_cfg_t;

    // Serial protocol phases.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_REG = 3'b010,
        ST_WR = 3'b011,
        ST_RD = 3'b100
    } ser_state_t;

    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Bit counter value between a start condition and the clock fall that closes it.
    localparam logic [3:0] BIT_ARMED = 4'hf;

endpackage : backlight_cfg_pkg

// ==== verilog/backlight_dimming_config_regs.sv ====
// Brightness, sink-current and dimming/spread configuration registers behind a two-wire
// serial slave. Assumes the bus pins are open drain, resolved outside this module.
`timescale 1ns/100ps
`default_nettype none

module backlight_dimming_config_regs
    import backlight_cfg_pkg::*;
#(
    // Arbitrary bus address; the value carries no meaning.
    parameter logic [6:0] DEVICE_ADDR = 7'h2a
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic config_write_allow_i,
    output logic [15:0] brightness_level_o,
    output logic [1:0] brightness_source_o,
    output logic [SINK_CODE_W-1:0] sink_current_code_o,
    output logic [1:0] spread_modulation_rate_o,
    output logic [1:0] spread_width_o,
    output logic random_spread_enable_o,
    output logic [RAMP_MS_W-1:0] ramp_time_ms_o,
    output logic smooth_ramp_o,
    output logic ramp_bypass_o,
    output logic [2:0] extra_resolution_bits_o
);

    // -------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // -------------------------------------------------------------------
    logic [1:0] scl_sync_r, sda_sync_r;
    logic scl_d_r, sda_d_r;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

    // -------------------------------------------------------------------
    // Serial slave and register bank
    // -------------------------------------------------------------------
    ser_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shreg_r, shreg_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] hi_r, hi_nxt;
    logic byte_sel_r, byte_sel_nxt;
    logic nack_r, nack_nxt;
    logic is_read_r, is_read_nxt;
    logic match_r, match_nxt;
    logic oe_r, oe_nxt;
    logic [15:0] bright_r, bright_nxt;
    logic [15:0] curr_r, curr_nxt;
    dim_cfg_t cfg_r, cfg_nxt;
    logic [1:0] src_r, src_nxt;
    logic [15:0] rd_word;

    always_comb begin
        if (ptr_r == OFS_BRIGHTNESS_LEVEL) begin
            rd_word = bright_r;
        end else if (ptr_r == OFS_SINK_CURRENT) begin
            rd_word = curr_r;
        end else if (ptr_r == OFS_DIM_SPREAD_CFG) begin
            rd_word = cfg_r;
        end else begin
            rd_word = 16'h0000;
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        ptr_nxt = ptr_r;
        hi_nxt = hi_r;
        byte_sel_nxt = byte_sel_r;
        nack_nxt = nack_r;
        is_read_nxt = is_read_r;
        match_nxt = match_r;
        oe_nxt = oe_r;
        bright_nxt = bright_r;
        curr_nxt = curr_r;
        cfg_nxt = cfg_r;
        src_nxt = src_r;
        if (start_det) begin
            state_nxt = ST_DEV;
            cnt_nxt = BIT_ARMED;
            oe_nxt = 1'b0;
        end else if (stop_det) begin
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end else if (state_r != ST_IDLE && scl_rise) begin
            if (cnt_r == BIT_ACK) begin
                nack_nxt = sda_s;
            end else if (state_r != ST_RD) begin
                shreg_nxt = {shreg_r[6:0], sda_s};
            end
        end else if (state_r != ST_IDLE && scl_fall) begin
            if (cnt_r == BIT_ARMED) begin
                // The clock fall that closes a start condition carries no bit.
                cnt_nxt = 4'h0;
            end else if (cnt_r < BIT_LAST) begin
                cnt_nxt = cnt_r + 4'h1;
                if (state_r == ST_RD) begin
                    shreg_nxt = {shreg_r[6:0], 1'b0};
                    oe_nxt = !shreg_r[6];
                end
            end else if (cnt_r == BIT_LAST) begin
                cnt_nxt = BIT_ACK;
                if (state_r == ST_DEV) begin
                    match_nxt = shreg_r[7:1] == DEVICE_ADDR;
                    is_read_nxt = shreg_r[0];
                    oe_nxt = shreg_r[7:1] == DEVICE_ADDR;
                end else begin
                    oe_nxt = state_r != ST_RD;
                end
            end else begin
                cnt_nxt = 4'h0;
                oe_nxt = 1'b0;
                case (state_r)
                    ST_DEV: begin
                        byte_sel_nxt = 1'b0;
                        if (!match_r) begin
                            state_nxt = ST_IDLE;
                        end else if (is_read_r) begin
                            state_nxt = ST_RD;
                            shreg_nxt = rd_word[15:8];
                            oe_nxt = !rd_word[15];
                        end else begin
                            state_nxt = ST_REG;
                        end
                    end
                    ST_REG: begin
                        ptr_nxt = shreg_r;
                        state_nxt = ST_WR;
                    end
                    ST_WR: begin
                        byte_sel_nxt = !byte_sel_r;
                        hi_nxt = shreg_r;
                        if (byte_sel_r) begin
                            ptr_nxt = ptr_r + OFS_STEP;
                            // Writes outside the allowed window are dropped; the pointer still advances.
                            if (config_write_allow_i) begin
                                if (ptr_r == OFS_BRIGHTNESS_LEVEL) begin
                                    bright_nxt = {hi_r, shreg_r};
                                end else if (ptr_r == OFS_SINK_CURRENT) begin
                                    curr_nxt = {hi_r, shreg_r};
                                end else if (ptr_r == OFS_DIM_SPREAD_CFG) begin
                                    cfg_nxt = dim_cfg_t'({hi_r, shreg_r});
                                end
                            end
                        end
                    end
                    ST_RD: begin
                        if (nack_r) begin
                            state_nxt = ST_IDLE;
                        end else begin
                            byte_sel_nxt = !byte_sel_r;
                            if (byte_sel_r) begin
                                shreg_nxt = rd_word[15:8];
                                oe_nxt = !rd_word[15];
                            end else begin
                                // Advancing here lets the next high byte come from the next word.
                                ptr_nxt = ptr_r + OFS_STEP;
                                shreg_nxt = rd_word[7:0];
                                oe_nxt = !rd_word[7];
                            end
                        end
                    end
                    default: state_nxt = ST_IDLE;
                endcase
            end
        end
        // Reserved codes stay stored while the last valid source keeps steering.
        if (cfg_r.brightness_source_select == SRC_PWM_INPUT ||
            cfg_r.brightness_source_select == SRC_REGISTER) begin
            src_nxt = cfg_r.brightness_source_select;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            shreg_r <= 8'h00;
            ptr_r <= 8'h00;
            hi_r <= 8'h00;
            byte_sel_r <= 1'b0;
            nack_r <= 1'b0;
            is_read_r <= 1'b0;
            match_r <= 1'b0;
            oe_r <= 1'b0;
            bright_r <= RST_BRIGHTNESS_LEVEL;
            curr_r <= RST_SINK_CURRENT;
            cfg_r <= dim_cfg_t'(RST_DIM_SPREAD_CFG);
            src_r <= SRC_PWM_INPUT;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            ptr_r <= ptr_nxt;
            hi_r <= hi_nxt;
            byte_sel_r <= byte_sel_nxt;
            nack_r <= nack_nxt;
            is_read_r <= is_read_nxt;
            match_r <= match_nxt;
            oe_r <= oe_nxt;
            bright_r <= bright_nxt;
            curr_r <= curr_nxt;
            cfg_r <= cfg_nxt;
            src_r <= src_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Registered configuration outputs
    // -------------------------------------------------------------------
    logic [RAMP_MS_W-1:0] ramp_lin, ramp_nxt;
    always_comb begin
        ramp_lin = RAMP_MS[cfg_r.ramp_duration_select];
        // Smooth ramps run half again as long as the linear figure.
        ramp_nxt = cfg_r.smooth_ramp_enable ? ramp_lin + (ramp_lin >> 1) : ramp_lin;
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            brightness_level_o <= RST_BRIGHTNESS_LEVEL;
            brightness_source_o <= SRC_PWM_INPUT;
            sink_current_code_o <= RST_SINK_CURRENT[SINK_CODE_W-1:0];
            spread_modulation_rate_o <= 2'h0;
            spread_width_o <= 2'h2;
            random_spread_enable_o <= 1'b0;
            ramp_time_ms_o <= 10'h12c;
            smooth_ramp_o <= 1'b1;
            ramp_bypass_o <= 1'b0;
            extra_resolution_bits_o <= 3'h0;
        end else begin
            sda_o <= 1'b0;
            sda_oe_o <= oe_r;
            brightness_level_o <= bright_r;
            brightness_source_o <= src_r;
            sink_current_code_o <= curr_r[SINK_CODE_W-1:0];
            spread_modulation_rate_o <= cfg_r.spread_modulation_rate;
            spread_width_o <= cfg_r.spread_width;
            random_spread_enable_o <= cfg_r.random_spread_enable;
            ramp_time_ms_o <= ramp_nxt;
            smooth_ramp_o <= cfg_r.smooth_ramp_enable;
            ramp_bypass_o <= cfg_r.ramp_duration_select == RAMP_OFF;
            extra_resolution_bits_o <= (cfg_r.extra_resolution_bits > DITHER_MAX) ?
                DITHER_MAX : cfg_r.extra_resolution_bits;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_low_byte_acked;
        state_r == ST_WR && byte_sel_r && cnt_r == BIT_ACK && scl_fall;
    endsequence

    a_src_valid_only: assert property (brightness_source_o == SRC_PWM_INPUT ||
        brightness_source_o == SRC_REGISTER) else $error("Reserved source in use.");
    a_src_follows: assert property (cfg_r.brightness_source_select == SRC_REGISTER |-> ##2
        brightness_source_o == SRC_REGISTER) else $error("Source did not follow.");
    a_current_out: assert property (##1 sink_current_code_o == $past(curr_r[11:0]))
        else $error("Current code mismatch.");
    a_width_out: assert property (##1 spread_width_o == $past(cfg_r.spread_width))
        else $error("Spread width mismatch.");
    a_rate_out: assert property (##1 spread_modulation_rate_o ==
        $past(cfg_r.spread_modulation_rate)) else $error("Rate mismatch.");
    a_random_out: assert property (##1 random_spread_enable_o ==
        $past(cfg_r.random_spread_enable)) else $error("Random spread mismatch.");
    a_bypass_ramp: assert property (ramp_bypass_o |-> ramp_time_ms_o == 10'h000)
        else $error("Bypass with nonzero ramp.");
    a_dither_range: assert property (extra_resolution_bits_o <= DITHER_MAX)
        else $error("Dither out of range.");
    a_smooth_longer: assert property (smooth_ramp_o && !ramp_bypass_o &&
        $stable(cfg_r) [*3] |-> ramp_time_ms_o > RAMP_MS[cfg_r.ramp_duration_select])
        else $error("Smooth ramp not stretched.");
    a_write_gated: assert property (s_low_byte_acked ##0 !config_write_allow_i |=>
        $stable(cfg_r) && $stable(curr_r) && $stable(bright_r))
        else $error("Write taken outside window.");
    a_hi_bits_kept: assert property (s_low_byte_acked ##0 config_write_allow_i &&
        ptr_r == OFS_SINK_CURRENT |=> curr_r == {$past(hi_r), $past(shreg_r)})
        else $error("Current word not stored.");

endmodule : backlight_dimming_config_regs

`default_nettype wire
